/* File: hdl/mpg_ports.sv */
// four parallel pin ports with avalon-mm register access
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps

module mpg_ports (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // pins
  input wire mpg_pkg::mpg_pins_t pins_in,
  output mpg_pkg::mpg_drive_t pins_drv,
  // shared functions
  input wire logic [3:0] tp_fn_out,
  input wire logic [7:0] lcd_seg_a,
  input wire logic [7:0] lcd_seg_b,
  output logic [3:0] tp_din,
  output logic [7:0] an_din,
  output logic [7:0] analog_sel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mpg_pkg::mpg_state_t q;
  mpg_pkg::mpg_state_t n;
  logic [5:0] idx;
  logic [7:0] rd_val;
  logic wr_lane;

  assign idx = address[7:2];
  assign wr_lane = write & byteenable[0];

  // read mux, pins taken from the filtered copy at request time
  always_comb begin
    rd_val = 8'h00;
    if (idx == mpg_pkg::IDX_TP_LAT) begin
      rd_val = {4'h0, q.tp_lat};
    end else if (idx == mpg_pkg::IDX_TP_PIN) begin
      rd_val = {4'h0, q.f.tp};
    end else if (idx == mpg_pkg::IDX_TP_TYPE) begin
      rd_val = {4'h0, q.tp_type};
    end else if (idx == mpg_pkg::IDX_SA_LAT) begin
      rd_val = q.sa_lat;
    end else if (idx == mpg_pkg::IDX_SA_PIN) begin
      rd_val = q.f.sa;
    end else if (idx == mpg_pkg::IDX_SA_SEG) begin
      rd_val = q.sa_seg;
    end else if (idx == mpg_pkg::IDX_SB_LAT) begin
      rd_val = q.sb_lat;
    end else if (idx == mpg_pkg::IDX_SB_PIN) begin
      rd_val = q.f.sb;
    end else if (idx == mpg_pkg::IDX_SB_SEG) begin
      rd_val = q.sb_seg;
    end else if (idx == mpg_pkg::IDX_AN_LAT) begin
      // outputs give latch, inputs give pin, latch-0 inputs give 0
      rd_val = q.an_lat & (q.an_dir | q.f.an);
    end else if (idx == mpg_pkg::IDX_AN_DIR) begin
      rd_val = q.an_dir;
    end else if (idx == mpg_pkg::IDX_CONV1) begin
      rd_val = 8'h00;
      rd_val[mpg_pkg::AN_DIS_BIT] = q.an_dis;
    end else begin
      rd_val = 8'h00; // unmapped reads zero
    end
  end

  // next state: pin filter, bus handshake, register writes, drive
  always_comb begin
    n = q;
    // three-stage synchroniser, change counted when stages 2 and 3 agree
    n.s1 = pins_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f = mpg_pkg::mpg_pins_t'((q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3)));
    case (q.bus)
      mpg_pkg::BUS_IDLE: begin
        if (read | write) begin
          n.bus = mpg_pkg::BUS_ACK;
        end
        if (read) begin
          n.rdata = rd_val;
        end
      end
      mpg_pkg::BUS_ACK: begin
        n.bus = mpg_pkg::BUS_IDLE;
        // writes land at the answer edge; pin read indices fall through
        if (wr_lane) begin
          if (idx == mpg_pkg::IDX_TP_LAT) begin
            n.tp_lat = writedata[3:0];
          end else if (idx == mpg_pkg::IDX_TP_TYPE) begin
            n.tp_type = writedata[3:0];
          end else if (idx == mpg_pkg::IDX_SA_LAT) begin
            n.sa_lat = writedata[7:0];
          end else if (idx == mpg_pkg::IDX_SA_SEG) begin
            n.sa_seg = writedata[7:0];
          end else if (idx == mpg_pkg::IDX_SB_LAT) begin
            n.sb_lat = writedata[7:0];
          end else if (idx == mpg_pkg::IDX_SB_SEG) begin
            n.sb_seg = writedata[7:0];
          end else if (idx == mpg_pkg::IDX_AN_LAT) begin
            n.an_lat = writedata[7:0];
          end else if (idx == mpg_pkg::IDX_AN_DIR) begin
            n.an_dir = writedata[7:0];
          end else if (idx == mpg_pkg::IDX_CONV1) begin
            n.an_dis = writedata[mpg_pkg::AN_DIS_BIT];
          end else begin
            n.an_dis = q.an_dis;
          end
        end
      end
      default: begin
        n.bus = mpg_pkg::BUS_IDLE;
      end
    endcase
    // timer port: latch gates the shared function; type picks drive
    n.drv.tp_out = n.tp_type & n.tp_lat & tp_fn_out;
    n.drv.tp_oe_n = ~n.tp_type & n.tp_lat & tp_fn_out;
    // segment ports: lcd owns selected pins, else latch pulls low
    n.drv.sa_out = n.sa_seg & lcd_seg_a;
    n.drv.sa_oe_n = ~n.sa_seg & n.sa_lat;
    n.drv.sb_out = n.sb_seg & lcd_seg_b;
    n.drv.sb_oe_n = ~n.sb_seg & n.sb_lat;
    // analog port: direction 1 drives latch, else released
    n.drv.an_out = n.an_dir & n.an_lat;
    n.drv.an_oe_n = ~n.an_dir;
  end

  // register the whole state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q.bus <= mpg_pkg::BUS_IDLE;
      q.rdata <= 8'h00;
      q.tp_lat <= mpg_pkg::TP_LAT_RST;
      q.tp_type <= mpg_pkg::TP_TYPE_RST;
      q.sa_lat <= mpg_pkg::SEG_LAT_RST;
      q.sa_seg <= mpg_pkg::SEG_SEL_RST;
      q.sb_lat <= mpg_pkg::SEG_LAT_RST;
      q.sb_seg <= mpg_pkg::SEG_SEL_RST;
      q.an_lat <= mpg_pkg::AN_LAT_RST;
      q.an_dir <= mpg_pkg::AN_DIR_RST;
      q.an_dis <= mpg_pkg::AN_DIS_RST;
      q.s1 <= mpg_pkg::PINS_RST;
      q.s2 <= mpg_pkg::PINS_RST;
      q.s3 <= mpg_pkg::PINS_RST;
      q.f <= mpg_pkg::PINS_RST;
      q.drv <= mpg_pkg::mpg_drive_t'(mpg_pkg::DRV_RST);
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // one wait cycle, answer in the second cycle of a request
  assign waitrequest = (read | write) & (q.bus != mpg_pkg::BUS_ACK);
  assign readdata = {24'h00_0000, q.rdata};
  assign pins_drv = q.drv;
  assign tp_din = q.f.tp;
  // digital input forced low unless input mode with latch 1
  assign an_din = q.f.an & q.an_lat & ~q.an_dir;
  assign analog_sel = {8{~q.an_dis}} & ~q.an_dir & ~q.an_lat;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  logic ack_wr;
  assign ack_wr = (q.bus == mpg_pkg::BUS_ACK) & wr_lane;

  a_reset_latches: assert property ($rose(resetn) |-> q.tp_lat == 4'hf
    && q.tp_type == 4'h0 && q.sa_lat == 8'hff && q.sb_lat == 8'hff)
    else $error("latches wrong after reset");
  a_reset_analog: assert property ($rose(resetn) |-> q.an_lat == 8'h00
    && q.an_dir == 8'h00 && q.an_dis && an_din == 8'h00)
    else $error("analog port wrong after reset");
  a_drive_push: assert property (ack_wr && idx == mpg_pkg::IDX_TP_TYPE
    && writedata[0] |=> !pins_drv.tp_oe_n[0])
    else $error("push-pull bit not driving");
  a_tp_upper_zero: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_TP_LAT |=> readdata[7:4] == 4'h0)
    else $error("timer port upper bits not zero");
  a_write_lands: assert property (ack_wr && idx == mpg_pkg::IDX_TP_LAT
    |=> q.tp_lat == $past(writedata[3:0]))
    else $error("latch write not taken at answer");
  a_pin_ro: assert property (ack_wr && idx == mpg_pkg::IDX_SA_PIN
    |=> $stable(q.sa_lat) && $stable(q.sb_lat) && $stable(q.tp_lat))
    else $error("pin read write changed a latch");
  a_pin_sample: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_TP_PIN |=> readdata[3:0] == $past(q.f.tp))
    else $error("pin read not sampled at request");
  a_seg_a_lcd: assert property (q.sa_seg[0] && $past(q.sa_seg[0])
    |-> pins_drv.sa_out[0] == $past(lcd_seg_a[0]) && !pins_drv.sa_oe_n[0])
    else $error("segment a pin not given to lcd");
  a_seg_b_lcd: assert property (q.sb_seg[0] && $past(q.sb_seg[0])
    |-> pins_drv.sb_out[0] == $past(lcd_seg_b[0]) && !pins_drv.sb_oe_n[0])
    else $error("segment b pin not given to lcd");
  a_analog_zero: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_AN_LAT |=> (readdata[7:0] & ~$past(q.an_lat)) == 8'h00)
    else $error("analog input bit read nonzero");
  a_analog_mode: assert property (!q.an_dis && q.an_dir == 8'h00
    && q.an_lat == 8'h00 |-> analog_sel == 8'hff && an_din == 8'h00)
    else $error("analog mode select wrong");
  a_wait_once: assert property ((read || write) && waitrequest
    && $stable(address) |=> !waitrequest || !(read || write))
    else $error("answer not in second cycle");

  // reset: pins released, segment selects cleared
  a_reset_drive: assert property ($rose(resetn) |-> pins_drv.tp_oe_n == 4'hf
    && pins_drv.sa_oe_n == 8'hff && pins_drv.sb_oe_n == 8'hff && pins_drv.an_oe_n == 8'hff)
    else $error("pins not released after reset");
  a_reset_select: assert property ($rose(resetn) |-> q.sa_seg == 8'h00
    && q.sb_seg == 8'h00)
    else $error("segment selects wrong after reset");

  // timer port drive type, every bit
  a_sink_no_high: assert property ((pins_drv.tp_out & ~q.tp_type) == 4'h0)
    else $error("open-drain bit driven high");
  a_push_drives: assert property ((pins_drv.tp_oe_n & q.tp_type) == 4'h0)
    else $error("push-pull bit released");

  // register reads
  a_tp_upper_pin: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_TP_PIN |=> readdata[7:4] == 4'h0)
    else $error("timer pin read upper bits not zero");
  a_tp_lat_read: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_TP_LAT |=> readdata[3:0] == $past(q.tp_lat))
    else $error("timer latch read wrong");
  a_sa_pin_read: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_SA_PIN |=> readdata[7:0] == $past(q.f.sa))
    else $error("segment a pin read not sampled");
  a_sb_pin_read: assert property (q.bus == mpg_pkg::BUS_IDLE && read
    && idx == mpg_pkg::IDX_SB_PIN |=> readdata[7:0] == $past(q.f.sb))
    else $error("segment b pin read not sampled");

  // segment ports in port mode
  a_seg_a_port: assert property ((pins_drv.sa_out & ~q.sa_seg) == 8'h00
    && pins_drv.sa_oe_n == (~q.sa_seg & q.sa_lat))
    else $error("segment a port pin drive wrong");
  a_seg_b_port: assert property ((pins_drv.sb_out & ~q.sb_seg) == 8'h00
    && pins_drv.sb_oe_n == (~q.sb_seg & q.sb_lat))
    else $error("segment b port pin drive wrong");

  // analog port modes
  a_analog_drive: assert property (pins_drv.an_oe_n == ~q.an_dir
    && pins_drv.an_out == (q.an_dir & q.an_lat))
    else $error("analog port drive wrong");
  a_input_forced: assert property ((an_din & (~q.an_lat | q.an_dir)) == 8'h00)
    else $error("digital input not forced low");
  a_sel_disabled: assert property (q.an_dis |-> analog_sel == 8'h00)
    else $error("analog select while disabled");
  a_dir_lands: assert property (ack_wr && idx == mpg_pkg::IDX_AN_DIR
    |=> q.an_dir == $past(writedata[7:0]))
    else $error("direction write not taken at answer");
  a_dis_lands: assert property (ack_wr && idx == mpg_pkg::IDX_CONV1
    |=> q.an_dis == $past(writedata[mpg_pkg::AN_DIS_BIT]))
    else $error("analog disable write not taken");

  // read-only pin registers and bus handshake
  a_pin_ro_tp: assert property (ack_wr && idx == mpg_pkg::IDX_TP_PIN
    |=> $stable(q.tp_lat) && $stable(q.tp_type))
    else $error("timer pin read write changed a register");
  a_pin_ro_sb: assert property (ack_wr && idx == mpg_pkg::IDX_SB_PIN
    |=> $stable(q.sb_lat) && $stable(q.sb_seg) && $stable(q.an_lat))
    else $error("segment b pin read write changed a register");
  a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  a_rdata_holds: assert property (!(q.bus == mpg_pkg::BUS_IDLE && read)
    |=> $stable(readdata))
    else $error("read data changed without a read");

  c_write_latch: cover property (ack_wr && idx == mpg_pkg::IDX_AN_LAT);
  c_read_pins: cover property (read && idx == mpg_pkg::IDX_SB_PIN && !waitrequest);
  c_analog_sel: cover property (analog_sel != 8'h00);
  c_push_pull: cover property (q.tp_type != 4'h0 && pins_drv.tp_oe_n != 4'hf);
  c_seg_select: cover property (q.sa_seg != 8'h00 || q.sb_seg != 8'h00);

endmodule // mpg_ports

/* File: hdl/mpg_pkg.sv */
// constants, types and register map of the four-port pin block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package mpg_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_TP_LAT = 6'h03;
  localparam logic [5:0] IDX_SA_LAT = 6'h05;
  localparam logic [5:0] IDX_AN_LAT = 6'h06;
  localparam logic [5:0] IDX_SB_LAT = 6'h07;
  localparam logic [5:0] IDX_TP_PIN = 6'h0a;
  localparam logic [5:0] IDX_SA_PIN = 6'h0b;
  localparam logic [5:0] IDX_AN_DIR = 6'h0c;
  localparam logic [5:0] IDX_SB_PIN = 6'h0d;
  localparam logic [5:0] IDX_TP_TYPE = 6'h10;
  localparam logic [5:0] IDX_SA_SEG = 6'h11;
  localparam logic [5:0] IDX_SB_SEG = 6'h12;
  localparam logic [5:0] IDX_CONV1 = 6'h13;

  // field position of the analog disable bit in converter control one
  localparam int unsigned AN_DIS_BIT = 0;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] TP_LAT_RST = 4'hf;
  localparam logic [3:0] TP_TYPE_RST = 4'h0;
  localparam logic [7:0] SEG_LAT_RST = 8'hff;
  localparam logic [7:0] SEG_SEL_RST = 8'h00;
  localparam logic [7:0] AN_LAT_RST = 8'h00;
  localparam logic [7:0] AN_DIR_RST = 8'h00;
  localparam logic AN_DIS_RST = 1'b1;
  localparam logic [27:0] PINS_RST = 28'h000_0000;
  // pin drive after reset: every output low, every pin released
  localparam logic [55:0] DRV_RST = 56'h0f_00ff_00ff_00ff;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } mpg_bus_t;

  // pin levels of all four ports
  typedef struct packed {
    logic [3:0] tp;
    logic [7:0] sa;
    logic [7:0] sb;
    logic [7:0] an;
  } mpg_pins_t;

  // pin drive, output enables active low
  typedef struct packed {
    logic [3:0] tp_out;
    logic [3:0] tp_oe_n;
    logic [7:0] sa_out;
    logic [7:0] sa_oe_n;
    logic [7:0] sb_out;
    logic [7:0] sb_oe_n;
    logic [7:0] an_out;
    logic [7:0] an_oe_n;
  } mpg_drive_t;

  // whole state of the block
  typedef struct packed {
    mpg_bus_t bus;
    logic [7:0] rdata;
    logic [3:0] tp_lat;
    logic [3:0] tp_type;
    logic [7:0] sa_lat;
    logic [7:0] sa_seg;
    logic [7:0] sb_lat;
    logic [7:0] sb_seg;
    logic [7:0] an_lat;
    logic [7:0] an_dir;
    logic an_dis;
    mpg_pins_t s1;
    mpg_pins_t s2;
    mpg_pins_t s3;
    mpg_pins_t f;
    mpg_drive_t drv;
  } mpg_state_t;

endpackage

/* File: tb/mpg_pins_model.sv */
// pin level model for the four ports
`timescale 1ns/100ps

module mpg_pins_model (
  // block drive and outside levels
  input wire mpg_pkg::mpg_drive_t drv,
  input wire mpg_pkg::mpg_pins_t ext,
  // resolved pin levels
  output mpg_pkg::mpg_pins_t pins
);
  // a released pin follows the outside source, all ones acting as pull-up
  always_comb begin
    pins.tp = (drv.tp_out & ~drv.tp_oe_n) | (ext.tp & drv.tp_oe_n);
    pins.sa = (drv.sa_out & ~drv.sa_oe_n) | (ext.sa & drv.sa_oe_n);
    pins.sb = (drv.sb_out & ~drv.sb_oe_n) | (ext.sb & drv.sb_oe_n);
    pins.an = (drv.an_out & ~drv.an_oe_n) | (ext.an & drv.an_oe_n);
  end
endmodule // mpg_pins_model

/* File: tb/mpg_ports_tb.sv */
// self-checking bench for the four-port pin block
`timescale 1ns/100ps

module mpg_ports_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  mpg_pkg::mpg_pins_t pins_in;
  mpg_pkg::mpg_pins_t ext = '1;
  mpg_pkg::mpg_drive_t pins_drv;
  logic [3:0] tp_fn_out = 4'hf;
  logic [7:0] lcd_seg_a = 8'h00;
  logic [7:0] lcd_seg_b = 8'h00;
  logic [3:0] tp_din;
  logic [7:0] an_din;
  logic [7:0] analog_sel;
  logic [31:0] rd;
  int errors = 0;
  int checks = 0;

  // 20 MHz clock
  always #25 mclk = ~mclk;

  mpg_ports DUT (.mclk(mclk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pins_in(pins_in), .pins_drv(pins_drv),
    .tp_fn_out(tp_fn_out), .lcd_seg_a(lcd_seg_a), .lcd_seg_b(lcd_seg_b),
    .tp_din(tp_din), .an_din(an_din), .analog_sel(analog_sel));

  mpg_pins_model pins_far (.drv(pins_drv), .ext(ext), .pins(pins_in));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    begin
      @(posedge mclk);
      address <= {idx, 2'b00};
      writedata <= {24'h00_0000, d};
      write <= wr;
      read <= ~wr;
      @(posedge mclk);
      // wait for the answer; only the watchdog ends a hang
      while (waitrequest !== 1'b0) begin
        @(posedge mclk);
      end
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    begin
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h00_0000, exp});
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    begin
      @(negedge mclk);
      chk({pins_drv.tp_oe_n, pins_drv.sa_oe_n}, 12'hfff);
      chk({analog_sel, an_din}, 16'h0000);
      rdc(mpg_pkg::IDX_TP_LAT, 8'h0f);
      rdc(mpg_pkg::IDX_TP_TYPE, 8'h00);
      rdc(mpg_pkg::IDX_SA_LAT, 8'hff);
      rdc(mpg_pkg::IDX_SB_LAT, 8'hff);
      rdc(mpg_pkg::IDX_AN_LAT, 8'h00);
      rdc(mpg_pkg::IDX_AN_DIR, 8'h00);
      rdc(mpg_pkg::IDX_CONV1, 8'h01);
    end
  endtask

  task automatic t_timer;
    begin
      bus(1'b1, mpg_pkg::IDX_TP_LAT, 8'h0f);
      bus(1'b1, mpg_pkg::IDX_TP_TYPE, 8'h05);
      @(negedge mclk);
      chk({pins_drv.tp_out, pins_drv.tp_oe_n}, 8'h5a);
      @(posedge mclk);
      tp_fn_out <= 4'h3;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      chk({pins_drv.tp_out, pins_drv.tp_oe_n}, 8'h12);
      chk(tp_din, 4'h3);
      rdc(mpg_pkg::IDX_TP_PIN, 8'h03);
      rdc(mpg_pkg::IDX_TP_LAT, 8'h0f);
      bus(1'b1, mpg_pkg::IDX_TP_TYPE, 8'h00);
    end
  endtask

  // shared by both segment ports; b picks the second one
  task automatic t_seg(input logic b);
    begin
      @(posedge mclk);
      lcd_seg_a <= 8'ha5;
      lcd_seg_b <= 8'ha5;
      bus(1'b1, b ? mpg_pkg::IDX_SB_SEG : mpg_pkg::IDX_SA_SEG, 8'h0f);
      bus(1'b1, b ? mpg_pkg::IDX_SB_LAT : mpg_pkg::IDX_SA_LAT, 8'h3c);
      @(negedge mclk);
      chk(b ? {pins_drv.sb_out, pins_drv.sb_oe_n} : {pins_drv.sa_out, pins_drv.sa_oe_n},
        16'h0530);
      rdc(b ? mpg_pkg::IDX_SB_SEG : mpg_pkg::IDX_SA_SEG, 8'h0f);
      repeat (4) @(posedge mclk);
      bus(1'b0, b ? mpg_pkg::IDX_SB_PIN : mpg_pkg::IDX_SA_PIN, 8'h00);
      chk(rd & 32'h0000_00f0, 32'h0000_0030);
      bus(1'b1, b ? mpg_pkg::IDX_SB_SEG : mpg_pkg::IDX_SA_SEG, 8'h00);
      bus(1'b1, b ? mpg_pkg::IDX_SB_LAT : mpg_pkg::IDX_SA_LAT, 8'hff);
    end
  endtask

  // writes to read-only and masked places change nothing; an unmapped read gives zero
  task automatic t_refuse;
    begin
      bus(1'b1, mpg_pkg::IDX_TP_PIN, 8'h00);
      bus(1'b1, mpg_pkg::IDX_SA_PIN, 8'h00);
      bus(1'b1, mpg_pkg::IDX_SB_PIN, 8'h00);
      byteenable <= 4'h0;
      bus(1'b1, mpg_pkg::IDX_SA_LAT, 8'h00);
      byteenable <= 4'hf;
      rdc(mpg_pkg::IDX_TP_LAT, 8'h0f);
      rdc(mpg_pkg::IDX_SA_LAT, 8'hff);
      rdc(mpg_pkg::IDX_SB_LAT, 8'hff);
      rdc(6'h3f, 8'h00);
    end
  endtask

  task automatic t_analog;
    begin
      @(posedge mclk);
      ext.an <= 8'hd0;
      bus(1'b1, mpg_pkg::IDX_CONV1, 8'h00);
      bus(1'b1, mpg_pkg::IDX_AN_LAT, 8'h33);
      bus(1'b1, mpg_pkg::IDX_AN_DIR, 8'h03);
      @(negedge mclk);
      chk({pins_drv.an_oe_n, pins_drv.an_out & 8'h03, analog_sel}, 24'hfc_03cc);
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      chk(an_din, 8'h10);
      rdc(mpg_pkg::IDX_AN_LAT, 8'h13);
      bus(1'b1, mpg_pkg::IDX_CONV1, 8'h01);
      @(negedge mclk);
      chk({analog_sel, an_din}, 16'h0010);
    end
  endtask

  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    begin
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_timer();
    t_seg(1'b0);
    t_seg(1'b1);
    t_refuse();
    t_analog();
    tally_and_finish();
  end

  // watchdog at 4000 cycles, far beyond the fewer than two hundred cycles the scenarios need
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // mpg_ports_tb
